// ==== rtl/rsr_readback.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - average offset is signed 8-bit; the demodulator decision level follows it one cycle later
// - average offset scaled so offset equals baud rate times value over 16
// - instantaneous IF offset readout, signed 8-bit, baud rate times value over 8
// - synth readback: calibration DAC in bits 7:4, charge pump current in 3:0
// - version readback: silicon version in 7:5, VCO band select in 4:0
// - VCO readback: comparator bit 7, reference above core bit 6, current 5:0
// - ADC readback: mixer input 7:6, in-phase 5:3, quadrature 2:0
// - two 8-bit readbacks of channel filter upper bits, in-phase and quadrature
// - gain offset is configured minus applied gain in 4:0; bits 7:5 read zero
module rsr_readback
	import rsr_pkg::*;
#(
	parameter int               CUR_W           = 6,
	parameter logic [2:0]       SILICON_VERSION = 3'h5  // arbitrary value
) (
	input  wire  logic              clk_i,
	input  wire  logic              sys_rst_i,
	input  wire  logic              psel_i,
	input  wire  logic              penable_i,
	input  wire  logic              pwrite_i,
	input  wire  logic        [9:0] paddr_i,
	input  wire  logic       [31:0] pwdata_i,
	input  wire  logic        [3:0] pstrb_i,
	output logic             [31:0] prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire  logic              inst_valid_i,
	input  wire  logic        [7:0] inst_freq_offset_i,
	input  wire  logic        [3:0] cal_dac_i,
	input  wire  logic        [3:0] charge_pump_current_i,
	input  wire  logic        [4:0] vco_band_select_i,
	input  wire  logic              freq_comp_i,
	input  wire  logic  [CUR_W-1:0] vco_reference_current_i,
	input  wire  logic  [CUR_W-1:0] vco_core_current_i,
	input  wire  logic        [5:0] item_a_i,
	input  wire  logic        [1:0] adc_mix_i,
	input  wire  logic        [2:0] adc_i_i,
	input  wire  logic        [2:0] adc_q_i,
	input  wire  logic        [7:0] filter_i_i,
	input  wire  logic        [7:0] filter_q_i,
	input  wire  logic        [4:0] configured_gain_i,
	input  wire  logic        [4:0] applied_gain_i,
	output logic              [7:0] decision_level_o
);

	// readback snapshots, refreshed every cycle
	logic [7:0] inst_freq_offset_r;
	logic [7:0] synth_cal_readback_r;
	logic [7:0] version_and_vco_band_r;
	logic [7:0] vco_cal_readback_r;
	logic [7:0] adc_sample_readback_r;
	logic [7:0] inphase_filter_readback_r;
	logic [7:0] quadrature_filter_readback_r;
	logic [7:0] gain_offset_readback_r;
	logic [1:0] avg_shift_r;
	logic [7:0] avg_freq_offset;
	logic       vco_comp_nxt;
	logic [4:0] gain_diff_nxt;

	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        pready_r;
	logic        pslverr_r;
	logic        setup_phase;
	logic        access_done;
	logic [7:0]  reg_index;

	rsr_avg_if avg ();

	rsr_avg_filter u_avg (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.avg       (avg.filter)
	);

	assign avg.sample_valid = inst_valid_i;
	assign avg.sample       = inst_freq_offset_i;
	assign avg.shift        = avg_shift_r;
	assign avg_freq_offset  = avg.level[15:8];

	function automatic logic is_mapped(input logic [9:0] addr);
		is_mapped = (addr[1:0] == 2'h0)
			&& (addr[9:2] >= IDX_AVG_FREQ_OFFSET)
			&& (addr[9:2] <= IDX_AVG_CTRL);
	endfunction

	assign reg_index   = paddr_i[9:2];
	assign setup_phase = psel_i && !penable_i;
	assign access_done = psel_i && penable_i && pready_r;

	// comparator and difference are formed here, not upstream
	always_comb begin
		vco_comp_nxt  = vco_reference_current_i > vco_core_current_i;
		gain_diff_nxt = configured_gain_i - applied_gain_i;
	end

	// live capture; no clear or acknowledge, so nothing can go stale
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			inst_freq_offset_r           <= READBACK_RST;
			synth_cal_readback_r         <= READBACK_RST;
			version_and_vco_band_r       <= READBACK_RST;
			vco_cal_readback_r           <= READBACK_RST;
			adc_sample_readback_r        <= READBACK_RST;
			inphase_filter_readback_r    <= READBACK_RST;
			quadrature_filter_readback_r <= READBACK_RST;
			gain_offset_readback_r       <= READBACK_RST;
		end else begin
			inst_freq_offset_r <= inst_freq_offset_i;
			synth_cal_readback_r <= {cal_dac_i, charge_pump_current_i};
			version_and_vco_band_r <= {SILICON_VERSION, vco_band_select_i};
			vco_cal_readback_r <= {freq_comp_i, vco_comp_nxt, item_a_i};
			adc_sample_readback_r <= {adc_mix_i, adc_i_i, adc_q_i};
			inphase_filter_readback_r <= filter_i_i;
			quadrature_filter_readback_r <= filter_q_i;
			gain_offset_readback_r <= {3'h0, gain_diff_nxt};
		end
	end

	// only the averaging control is writable; readback writes fall away
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avg_shift_r <= AVG_SHIFT_RST;
		end else if (access_done && pwrite_i && pstrb_i[0]
			&& reg_index == IDX_AVG_CTRL && paddr_i[1:0] == 2'h0) begin
			avg_shift_r <= pwdata_i[AVG_SHIFT_LSB +: 2];
		end
	end

	always_comb begin
		prdata_nxt = PRDATA_RST;
		unique case (reg_index)
			IDX_AVG_FREQ_OFFSET:   prdata_nxt[7:0] = avg_freq_offset;
			IDX_INST_FREQ_OFFSET:  prdata_nxt[7:0] = inst_freq_offset_r;
			IDX_SYNTH_CAL:         prdata_nxt[7:0] = synth_cal_readback_r;
			IDX_VERSION_VCO_BAND:  prdata_nxt[7:0] = version_and_vco_band_r;
			IDX_VCO_CAL:           prdata_nxt[7:0] = vco_cal_readback_r;
			IDX_ADC_SAMPLE:        prdata_nxt[7:0] = adc_sample_readback_r;
			IDX_INPHASE_FILTER:    prdata_nxt[7:0] = inphase_filter_readback_r;
			IDX_QUADRATURE_FILTER: prdata_nxt[7:0] = quadrature_filter_readback_r;
			IDX_GAIN_OFFSET:       prdata_nxt[7:0] = gain_offset_readback_r;
			IDX_AVG_CTRL:          prdata_nxt[1:0] = avg_shift_r;
			default:               prdata_nxt = PRDATA_RST;
		endcase
		if (!is_mapped(paddr_i) || pwrite_i) begin
			prdata_nxt = PRDATA_RST;
		end
	end

	// answer is prepared during setup, so access never waits
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= PRDATA_RST;
		end else begin
			pready_r  <= setup_phase;
			pslverr_r <= setup_phase && !is_mapped(paddr_i);
			if (setup_phase) begin
				prdata_r <= prdata_nxt;
			end
		end
	end

	// decision level has its own flop, loaded from the average readback and one cycle behind it
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			decision_level_o <= READBACK_RST;
		end else begin
			decision_level_o <= avg_freq_offset_nxt();
		end
	end

	function automatic logic [7:0] avg_freq_offset_nxt();
		avg_freq_offset_nxt = avg_freq_offset;
	endfunction

	assign prdata_o  = prdata_r;
	assign pready_o  = pready_r;
	assign pslverr_o = pslverr_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	ready_timing_a: assert property (
		psel_i && !penable_i |=> pready_r ##1 !pready_r)
		else $error("pready not exactly one cycle after setup");
	error_unmapped_a: assert property (
		pslverr_r |-> pready_r && !is_mapped($past(paddr_i)))
		else $error("error answer on a mapped address");
	decision_match_a: assert property (
		decision_level_o == $past(avg.level[15:8]))
		else $error("decision level differs from average readback");
	avg_read_a: assert property (
		setup_phase && !pwrite_i && reg_index == IDX_AVG_FREQ_OFFSET
		&& paddr_i[1:0] == 2'h0 |=> prdata_r == {24'h0, $past(avg_freq_offset)})
		else $error("average offset read returned wrong value");
	synth_fields_a: assert property (
		##1 synth_cal_readback_r[7:CAL_DAC_LSB] == $past(cal_dac_i)
		&& synth_cal_readback_r[3:0] == $past(charge_pump_current_i))
		else $error("synth calibration fields misplaced");
	version_field_a: assert property (
		version_and_vco_band_r[7:VERSION_LSB] == SILICON_VERSION
		|| $past(sys_rst_i))
		else $error("version code missing from readback");
	vco_comp_a: assert property (
		vco_reference_current_i > vco_core_current_i
		|=> vco_cal_readback_r[VCO_COMP_BIT])
		else $error("comparator bit low with reference above core");
	adc_fields_a: assert property (
		##1 adc_sample_readback_r[7:ADC_MIX_LSB] == $past(adc_mix_i)
		&& adc_sample_readback_r[5:ADC_I_LSB] == $past(adc_i_i))
		else $error("adc readback fields misplaced");
	gain_offset_a: assert property (
		##1 gain_offset_readback_r[7:5] == 3'h0
		&& gain_offset_readback_r[4:0]
		== 5'($past(configured_gain_i) - $past(applied_gain_i)))
		else $error("gain offset readback wrong");
	write_ignored_a: assert property (
		access_done && pwrite_i |-> prdata_r == PRDATA_RST)
		else $error("write returned read data");
	shift_write_a: assert property (
		access_done && pwrite_i && reg_index != IDX_AVG_CTRL
		|=> $stable(avg_shift_r))
		else $error("readback write altered control");
	inst_live_a: assert property (
		##2 inst_freq_offset_r == $past(inst_freq_offset_i))
		else $error("instantaneous offset not tracking input");

	// field checks the basic set leaves open, then bus answer checks, then averaging control write checks
	vco_comp_low_a: assert property (
		!(vco_reference_current_i > vco_core_current_i)
		|=> !vco_cal_readback_r[VCO_COMP_BIT])
		else $error("comparator bit high with reference not above core");

	freq_comp_a: assert property (
		##1 vco_cal_readback_r[FREQ_COMP_BIT] == $past(freq_comp_i)
		&& vco_cal_readback_r[5:0] == $past(item_a_i))
		else $error("comparator output or calibration current misplaced");

	adc_q_field_a: assert property (
		##1 adc_sample_readback_r[2:0] == $past(adc_q_i))
		else $error("quadrature adc field misplaced");

	filter_fields_a: assert property (
		##1 inphase_filter_readback_r == $past(filter_i_i)
		&& quadrature_filter_readback_r == $past(filter_q_i))
		else $error("channel filter readback not tracking");

	band_field_a: assert property (
		##1 version_and_vco_band_r[4:0] == $past(vco_band_select_i))
		else $error("vco band field misplaced");

	inst_read_a: assert property (
		setup_phase && !pwrite_i && reg_index == IDX_INST_FREQ_OFFSET
		&& paddr_i[1:0] == 2'h0
		|=> prdata_r == {24'h0, $past(inst_freq_offset_r)})
		else $error("instantaneous offset read returned wrong value");

	gain_read_a: assert property (
		setup_phase && !pwrite_i && reg_index == IDX_GAIN_OFFSET
		&& paddr_i[1:0] == 2'h0
		|=> prdata_r == {24'h0, $past(gain_offset_readback_r)})
		else $error("gain offset read returned wrong value");

	upper_zero_a: assert property (
		setup_phase |=> prdata_r[31:8] == 24'h0)
		else $error("read data above bit 7 not zero");

	unmapped_zero_a: assert property (
		setup_phase && !is_mapped(paddr_i) |=> prdata_r == PRDATA_RST)
		else $error("unmapped read returned data");

	mapped_ok_a: assert property (
		setup_phase && is_mapped(paddr_i) |=> !pslverr_r)
		else $error("mapped access answered with error");

	access_error_a: assert property (
		access_done |-> pslverr_r == !is_mapped(paddr_i))
		else $error("error flag disagrees with address in access");

	error_pulse_a: assert property (
		pslverr_r |=> !pslverr_r)
		else $error("error flag stood longer than one cycle");

	ready_idle_a: assert property (
		!setup_phase |=> !pready_r && !pslverr_r)
		else $error("answer without a setup cycle");

	prdata_hold_a: assert property (
		!setup_phase |=> $stable(prdata_r))
		else $error("read data changed outside setup");

	ctrl_write_a: assert property (
		access_done && pwrite_i && pstrb_i[0]
		&& reg_index == IDX_AVG_CTRL && paddr_i[1:0] == 2'h0
		|=> avg_shift_r == $past(pwdata_i[AVG_SHIFT_LSB +: 2]))
		else $error("averaging control write lost");

	strobe_off_a: assert property (
		access_done && pwrite_i && !pstrb_i[0] |=> $stable(avg_shift_r))
		else $error("control changed by a write without its lane");

	shift_hold_a: assert property (
		!(access_done && pwrite_i) |=> $stable(avg_shift_r))
		else $error("averaging control moved without a write");
endmodule
`default_nettype wire

// ==== rtl/rsr_pkg.sv ====
package rsr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_AVG_FREQ_OFFSET   = 8'h43;
	localparam logic [7:0] IDX_INST_FREQ_OFFSET  = 8'h44;
	localparam logic [7:0] IDX_SYNTH_CAL         = 8'h45;
	localparam logic [7:0] IDX_VERSION_VCO_BAND  = 8'h46;
	localparam logic [7:0] IDX_VCO_CAL           = 8'h47;
	localparam logic [7:0] IDX_ADC_SAMPLE        = 8'h48;
	localparam logic [7:0] IDX_INPHASE_FILTER    = 8'h49;
	localparam logic [7:0] IDX_QUADRATURE_FILTER = 8'h4A;
	localparam logic [7:0] IDX_GAIN_OFFSET       = 8'h4B;
	localparam logic [7:0] IDX_AVG_CTRL          = 8'h4C;

	// field positions
	localparam int CAL_DAC_LSB      = 4;
	localparam int VERSION_LSB      = 5;
	localparam int VCO_COMP_BIT     = 6;
	localparam int FREQ_COMP_BIT    = 7;
	localparam int ADC_MIX_LSB      = 6;
	localparam int ADC_I_LSB        = 3;
	localparam int AVG_SHIFT_LSB    = 0;

	// reset values
	localparam logic [1:0]  AVG_SHIFT_RST = 2'h2;
	localparam logic [7:0]  READBACK_RST  = 8'h00;
	localparam logic [31:0] PRDATA_RST    = 32'h0000_0000;

	// average offset is in baud/16 units, instantaneous in baud/8 units,
	// so one instantaneous step is two average steps; saturates at 8 bits
	function automatic logic [7:0] rsr_double_sat(input logic [7:0] v);
		logic [8:0] d;
		d = {v, 1'b0};
		if (v[7] != v[6]) begin
			rsr_double_sat = v[7] ? 8'h80 : 8'h7F;
		end else begin
			rsr_double_sat = d[7:0];
		end
	endfunction

endpackage

// ==== rtl/rsr_avg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rsr_avg_if;
	logic              sample_valid;
	logic        [7:0] sample;
	logic        [1:0] shift;
	logic       [15:0] level;

	modport feeder (
		output sample_valid,
		output sample,
		output shift,
		input  level
	);

	modport filter (
		input  sample_valid,
		input  sample,
		input  shift,
		output level
	);
endinterface
`default_nettype wire

// ==== rtl/rsr_avg_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsr_avg_filter
	import rsr_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	rsr_avg_if.filter avg
);

	logic        [15:0] level_r;
	logic        [15:0] level_nxt;
	logic        [15:0] target;
	logic signed [16:0] delta;
	logic signed [16:0] step;

	// level is 8.8 fixed point in baud/16 units
	always_comb begin
		target = {rsr_double_sat(avg.sample), 8'h00};
		delta  = $signed({target[15], target}) - $signed({level_r[15], level_r});
		step   = delta >>> avg.shift;
		level_nxt = level_r + step[15:0];
	end

	// first-order average; larger shift gives slower, quieter level
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			level_r <= 16'h0000;
		end else if (avg.sample_valid) begin
			level_r <= level_nxt;
		end
	end

	assign avg.level = level_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	level_hold_a: assert property (!avg.sample_valid |=> $stable(level_r))
		else $error("average level moved without a sample");
	level_direct_a: assert property (
		avg.sample_valid && avg.shift == 2'h0
		|=> level_r == {rsr_double_sat($past(avg.sample)), 8'h00})
		else $error("unfiltered level is not twice the sample");
	level_settle_a: assert property (
		(avg.sample_valid && avg.shift == 2'h1 && $stable(avg.sample)) [*8]
		|-> $signed(level_r[15:8]) - $signed(rsr_double_sat(avg.sample)) <= 1
		 && $signed(rsr_double_sat(avg.sample)) - $signed(level_r[15:8]) <= 1)
		else $error("average did not settle to steady offset");
endmodule
`default_nettype wire

// ==== rtl/rsr_unused_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== sim/radio_status_readback_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module radio_status_readback_tb
	import rsr_pkg::*;
;
	localparam logic [2:0] VER = 3'h5;  // arbitrary value

	logic        clk_i     = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic  [9:0] paddr_i   = 10'h000;
	logic [31:0] pwdata_i  = 32'h0000_0000;
	logic  [3:0] pstrb_i   = 4'hF;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        valid     = 1'b0;
	logic  [7:0] inst      = 8'h00;
	logic  [3:0] dac       = 4'h0;
	logic  [3:0] chp       = 4'h0;
	logic  [4:0] band      = 5'h00;
	logic        fcomp     = 1'b0;
	logic  [5:0] vref      = 6'h00;
	logic  [5:0] vcore     = 6'h00;
	logic  [5:0] cal       = 6'h00;
	logic  [1:0] mix       = 2'h0;
	logic  [2:0] adci      = 3'h0;
	logic  [2:0] adcq      = 3'h0;
	logic  [7:0] fil_i     = 8'h00;
	logic  [7:0] fil_q     = 8'h00;
	logic  [4:0] cfg       = 5'h00;
	logic  [4:0] app       = 5'h00;
	logic  [7:0] decision_level_o;
	int          failures    = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	always #2 clk_i = ~clk_i;

	rsr_readback #(.CUR_W(6), .SILICON_VERSION(VER)) dut_u (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .inst_valid_i(valid),
		.inst_freq_offset_i(inst), .cal_dac_i(dac),
		.charge_pump_current_i(chp), .vco_band_select_i(band),
		.freq_comp_i(fcomp), .vco_reference_current_i(vref),
		.vco_core_current_i(vcore), .item_a_i(cal), .adc_mix_i(mix),
		.adc_i_i(adci), .adc_q_i(adcq), .filter_i_i(fil_i),
		.filter_q_i(fil_q), .configured_gain_i(cfg),
		.applied_gain_i(app), .decision_level_o(decision_level_o)
	);

	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard, whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx,
			input logic [1:0] lo, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= wr;
		paddr_i   <= {idx, lo};
		pwdata_i  <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// wait for pready; the hang guard ends this wait if pready never rises
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [1:0] lo,
			input logic [7:0] exp, input logic experr);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, idx, lo, 32'h0000_0000, rd, err);
		check(rd, {24'h00_0000, exp});
		check({31'h0, err}, {31'h0, experr});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, idx, 2'h0, wd, rd, err);
	endtask

	// expectations built from the bench's own copies of the inputs
	task automatic check_all();
		logic [4:0] diff;
		logic       above;
		repeat (3) @(posedge clk_i);
		diff = cfg - app;
		above = vref > vcore;
		rd_chk(IDX_INST_FREQ_OFFSET, 2'h0, inst, 1'b0);
		rd_chk(IDX_SYNTH_CAL, 2'h0, {dac, chp}, 1'b0);
		rd_chk(IDX_VERSION_VCO_BAND, 2'h0, {VER, band}, 1'b0);
		rd_chk(IDX_VCO_CAL, 2'h0, {fcomp, above, cal}, 1'b0);
		rd_chk(IDX_ADC_SAMPLE, 2'h0, {mix, adci, adcq}, 1'b0);
		rd_chk(IDX_INPHASE_FILTER, 2'h0, fil_i, 1'b0);
		rd_chk(IDX_QUADRATURE_FILTER, 2'h0, fil_q, 1'b0);
		rd_chk(IDX_GAIN_OFFSET, 2'h0, {3'h0, diff}, 1'b0);
	endtask

	task automatic field_map();
		@(posedge clk_i);
		{dac, chp, band, fcomp} <= {4'hA, 4'h3, 5'h16, 1'b1};
		{vref, vcore, cal} <= {6'h20, 6'h10, 6'h2D};
		{mix, adci, adcq, inst} <= {2'h2, 3'h5, 3'h3, 8'hE7};
		{fil_i, fil_q, cfg, app} <= {8'hC4, 8'h3B, 5'h04, 5'h09};
		check_all();
		@(posedge clk_i);
		{dac, chp, band, fcomp} <= {4'h5, 4'hC, 5'h09, 1'b0};
		{vref, vcore, cal} <= {6'h11, 6'h11, 6'h12};
		{mix, adci, adcq, inst} <= {2'h1, 3'h2, 3'h6, 8'h31};
		{fil_i, fil_q, cfg, app} <= {8'h5A, 8'hA5, 5'h1F, 5'h00};
		check_all();
	endtask

	// writes must leave contents alone, new input values still show after them
	task automatic write_ignored();
		for (int i = 8'h43; i <= 8'h4B; i++) begin
			wr(i[7:0], 32'hFFFF_FFFF);
		end
		check_all();
		@(posedge clk_i);
		{cfg, app, vref, vcore} <= {5'h00, 5'h01, 6'h00, 6'h3F};
		check_all();
	endtask

	// shift 0 makes the average equal twice the sample, saturated
	task automatic average();
		logic [7:0] tbl [5][2];
		tbl = '{'{8'h10, 8'h20}, '{8'h50, 8'h7F}, '{8'hB0, 8'h80},
			'{8'hC0, 8'h80}, '{8'h3F, 8'h7E}};
		rd_chk(IDX_AVG_CTRL, 2'h0, 8'h02, 1'b0);
		wr(IDX_AVG_CTRL, 32'h0000_0000);
		rd_chk(IDX_AVG_CTRL, 2'h0, 8'h00, 1'b0);
		pstrb_i <= 4'hE;
		wr(IDX_AVG_CTRL, 32'h0000_0003);
		pstrb_i <= 4'hF;
		rd_chk(IDX_AVG_CTRL, 2'h0, 8'h00, 1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i);
			valid <= 1'b1;
			inst  <= tbl[i][0];
			repeat (4) @(posedge clk_i);
			rd_chk(IDX_AVG_FREQ_OFFSET, 2'h0, tbl[i][1], 1'b0);
			check({24'h0, decision_level_o}, {24'h0, tbl[i][1]});
		end
		// slower averages must still settle on twice the sample
		wr(IDX_AVG_CTRL, 32'h0000_0001);
		@(posedge clk_i);
		inst <= 8'h20;
		repeat (20) @(posedge clk_i);
		rd_chk(IDX_AVG_FREQ_OFFSET, 2'h0, 8'h40, 1'b0);
		check({24'h0, decision_level_o}, 32'h0000_0040);
		wr(IDX_AVG_CTRL, 32'h0000_0003);
		@(posedge clk_i);
		inst <= 8'hE0;
		repeat (100) @(posedge clk_i);
		rd_chk(IDX_AVG_FREQ_OFFSET, 2'h0, 8'hC0, 1'b0);
		check({24'h0, decision_level_o}, 32'h0000_00C0);
		// without a valid sample the average must hold
		@(posedge clk_i);
		valid <= 1'b0;
		inst  <= 8'h10;
		repeat (4) @(posedge clk_i);
		rd_chk(IDX_AVG_FREQ_OFFSET, 2'h0, 8'hC0, 1'b0);
	endtask

	task automatic unmapped();
		logic [31:0] rd;
		logic        err;
		rd_chk(8'h4D, 2'h0, 8'h00, 1'b1);
		rd_chk(8'h00, 2'h0, 8'h00, 1'b1);
		rd_chk(IDX_SYNTH_CAL, 2'h1, 8'h00, 1'b1);
		apb(1'b1, 8'h4D, 2'h0, 32'h0000_00FF, rd, err);
		check({31'h0, err}, 32'h0000_0001);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		field_map();
		write_ignored();
		average();
		unmapped();
		conclude();
	end
endmodule
`default_nettype wire
